// File: src/adc_sequencer_control.v
// How it works
// - Reset clears ctrl_a enable, ref, irq bits
// - Clearing enable aborts, clears flags, start
// - Internal reference powered only while enabled
// - Irq enable zero holds request low
// - Irq high while done set and enabled
// - Reset clears ctrl_b; fixed field layout
// - Channel select routes input; scan start
// - Repeat restarts after each completion
// - Burst converts four channels, else one
// - Start cleared finishes current, no more
// - Single modes auto-clear start on finish
// - Reset clears ctrl_c delay and divider
// - Divider 1 to 32 by code
// - Sampling delay 1 to 64 clocks
// - Results stored in four slots in order
// - Results untouched by reset
// - Reading any result clears done
// - Index loads 3 on start rise
// - Overwrite unread sets overrun, write-1 clears
// - Single continuous cycles slots, done after four
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`include "adc_seq_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the analog core: fixed conversion length, result taken from a pin bus
module adc_conv_core #(
	parameter CONV_LEN = 10
) (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       convTick,
	input  wire       convStart,
	input  wire [7:0] sampleIn,
	output reg        convDone,
	output reg  [7:0] convResult
);
	reg  [3:0] count;
	reg        running;
	always @(posedge clk_sys) begin
		convDone <= 1'b0;
		if (rst) begin
			running    <= 1'b0;
			count      <= 4'h0;
			convResult <= `RST_BYTE;
		end else if (convStart) begin
			running <= 1'b1;
			count   <= 4'h0;
		end else if (running && convTick) begin
			if (count == CONV_LEN[3:0] - 4'h1) begin
				running    <= 1'b0;
				convDone   <= 1'b1;
				convResult <= sampleIn;
			end else begin
				count <= count + 4'h1;
			end
		end
	end
endmodule // adc_conv_core

module adc_sequencer_control (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        warmRst,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire [7:0]  sampleIn,
	output reg  [2:0]  inputSelect,
	output wire        internalRefOn,
	output wire        converterPowered,
	output wire        irqRequest
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_CONV = 2'h2;

	reg  [7:0] ctrlA;
	reg  [7:0] ctrlB;
	reg  [7:0] ctrlC;
	reg  [7:0] result [0:3];
	reg  [3:0] slotFull;
	reg        convDoneFlag;
	reg        busy;
	reg        overrun;
	reg  [1:0] lastIndex;
	reg  [1:0] state;
	reg  [1:0] burstCount;
	reg  [1:0] writeSlot;
	reg  [5:0] divCount;
	reg  [6:0] delayCount;
	reg        convTick;
	reg        convStart;
	reg        phaseValid;
	reg        phaseWrite;
	reg  [7:0] phaseAddr;
	wire       convDone;
	wire [7:0] convResult;
	wire       enable;
	wire       startBit;
	wire       wrA;
	wire       wrB;
	wire       wrC;
	wire       wrS;
	wire       rdResult;
	wire       startRise;
	wire [5:0] divLimit;
	wire [6:0] delayLimit;
	reg  [7:0] statusByte;
	reg  [7:0] readByte;

	assign enable   = ctrlA[`A_ENABLE];
	assign startBit = ctrlB[`B_START];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign internalRefOn    = ctrlA[`A_INTERNAL_REF_SELECT] & enable;
	assign converterPowered = enable;
	assign irqRequest = ctrlA[`A_IRQEN] & convDoneFlag;

	// Address phase captured, action in data phase
	always @(posedge clk_sys) begin
		if (rst) begin
			phaseValid <= 1'b0;
			phaseWrite <= 1'b0;
			phaseAddr  <= `RST_BYTE;
		end else if (hready) begin
			phaseValid <= hsel & (htrans == `HTRANS_NONSEQ) & (hsize == `HSIZE_WORD);
			phaseWrite <= hwrite;
			phaseAddr  <= haddr;
		end
	end

	assign wrA = phaseValid & phaseWrite & (phaseAddr == `OFS_CTRL_A);
	assign wrB = phaseValid & phaseWrite & (phaseAddr == `OFS_CTRL_B);
	assign wrC = phaseValid & phaseWrite & (phaseAddr == `OFS_CTRL_C);
	assign wrS = phaseValid & phaseWrite & (phaseAddr == `OFS_STATUS);
	assign rdResult = phaseValid & ~phaseWrite & (phaseAddr[7:4] == `RESULT_PAGE) & (phaseAddr[1:0] == 2'h0);
	assign startRise = wrB & hwdata[`B_START] & ~startBit;

	always @* begin
		statusByte = `RST_BYTE;
		statusByte[`S_DONE]    = convDoneFlag;
		statusByte[`S_BUSY]    = busy;
		statusByte[`S_OVERRUN] = overrun;
		statusByte[`S_IDX_HI:`S_IDX_LO] = lastIndex;
		case (phaseAddr)
			`OFS_STATUS:  readByte = statusByte;
			`OFS_CTRL_A:  readByte = ctrlA;
			`OFS_CTRL_B:  readByte = ctrlB;
			`OFS_CTRL_C:  readByte = ctrlC;
			`OFS_RESULT0: readByte = result[0];
			`OFS_RESULT1: readByte = result[1];
			`OFS_RESULT2: readByte = result[2];
			`OFS_RESULT3: readByte = result[3];
			default:      readByte = `RST_BYTE;
		endcase
		hrdata = {24'h000000, readByte};
	end

	// Divider: one-cycle converter clock enable
	assign divLimit = (ctrlC[`C_DIV_HI:`C_DIV_LO] > 3'h5) ? 6'h00 :
		(6'h01 << ctrlC[`C_DIV_HI:`C_DIV_LO]) - 6'h01;
	always @(posedge clk_sys) begin
		if (rst || !enable) begin
			divCount <= 6'h00;
			convTick <= 1'b0;
		end else if (divCount >= divLimit) begin
			divCount <= 6'h00;
			convTick <= 1'b1;
		end else begin
			divCount <= divCount + 6'h01;
			convTick <= 1'b0;
		end
	end

	assign delayLimit = (ctrlC[`C_DELAY_HI:`C_DELAY_LO] == 3'h7) ? 7'h00 :
		(7'h01 << ctrlC[`C_DELAY_HI:`C_DELAY_LO]) - 7'h01;

	adc_conv_core #(
		.CONV_LEN(`CONV_CLOCKS)
	) u_core (
		.clk_sys    (clk_sys),
		.rst        (rst | ~enable),
		.convTick   (convTick),
		.convStart  (convStart),
		.sampleIn   (sampleIn),
		.convDone   (convDone),
		.convResult (convResult)
	);

	// Control registers and sequencer
	always @(posedge clk_sys) begin
		convStart <= 1'b0;
		if (rst) begin
			ctrlA        <= `RST_BYTE;
			ctrlB        <= `RST_BYTE;
			ctrlC        <= `RST_BYTE;
			convDoneFlag <= 1'b0;
			busy         <= 1'b0;
			overrun      <= 1'b0;
			lastIndex    <= `IDX_START;
			state        <= ST_IDLE;
			burstCount   <= 2'h0;
			writeSlot    <= 2'h0;
			delayCount   <= 7'h00;
			inputSelect  <= 3'h0;
			slotFull     <= 4'h0;
		end else begin
			if (wrA)
				ctrlA <= hwdata[7:0] & `A_MASK;
			if (wrC)
				ctrlC <= hwdata[7:0] & `C_MASK;
			if (wrB)
				ctrlB <= hwdata[7:0] & `B_MASK;
			if (startRise) begin
				lastIndex   <= `IDX_START;
				writeSlot   <= 2'h0;
				burstCount  <= 2'h0;
				inputSelect <= hwdata[`B_CHAN_HI:`B_CHAN_LO];
			end
			if (rdResult) begin
				convDoneFlag <= 1'b0;
				slotFull[phaseAddr[3:2]] <= 1'b0;
			end
			if (wrS && hwdata[`S_OVERRUN])
				overrun <= 1'b0;
			case (state)
				ST_IDLE: begin
					busy <= 1'b0;
					if (startRise && enable) begin
						state      <= ST_WAIT;
						delayCount <= 7'h00;
					end
				end
				ST_WAIT: begin
					busy <= 1'b1;
					if (convTick) begin
						if (delayCount >= delayLimit) begin
							state     <= ST_CONV;
							convStart <= 1'b1;
						end else begin
							delayCount <= delayCount + 7'h01;
						end
					end
				end
				ST_CONV: begin
					busy <= 1'b1;
					if (convDone) begin
						result[writeSlot] <= convResult;
						slotFull[writeSlot] <= 1'b1;
						lastIndex <= writeSlot;
						if (slotFull[writeSlot] && !(rdResult && phaseAddr[3:2] == writeSlot))
							overrun <= 1'b1;
						writeSlot  <= writeSlot + 2'h1;
						delayCount <= 7'h00;
						if (ctrlB[`B_BURST]) begin
							inputSelect <= inputSelect + 3'h1;
							burstCount  <= burstCount + 2'h1;
							if (burstCount == 2'h3) begin
								convDoneFlag <= 1'b1;
								inputSelect  <= ctrlB[`B_CHAN_HI:`B_CHAN_LO];
								if (ctrlB[`B_REPEAT] && startBit) begin
									state <= ST_WAIT;
								end else begin
									state <= ST_IDLE;
									busy  <= 1'b0;
									if (!ctrlB[`B_REPEAT])
										ctrlB[`B_START] <= 1'b0;
								end
							end else begin
								state <= ST_WAIT;
							end
						end else if (ctrlB[`B_REPEAT]) begin
							if (writeSlot == 2'h3 || !startBit)
								convDoneFlag <= 1'b1;
							if (startBit) begin
								state <= ST_WAIT;
							end else begin
								state <= ST_IDLE;
								busy  <= 1'b0;
							end
						end else begin
							convDoneFlag    <= 1'b1;
							ctrlB[`B_START] <= 1'b0;
							state           <= ST_IDLE;
							busy            <= 1'b0;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
			if (!enable || (wrA && !hwdata[`A_ENABLE])) begin
				state           <= ST_IDLE;
				busy            <= 1'b0;
				convDoneFlag    <= 1'b0;
				overrun         <= 1'b0;
				ctrlB[`B_START] <= 1'b0;
				convStart       <= 1'b0;
			end
		end
	end
	// Result storage has no reset so warm reset keeps it
	wire unusedWarm = warmRst;
endmodule // adc_sequencer_control
`default_nettype wire

// File: src/adc_seq_defs.vh
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
// Register byte offsets on the AHB-Lite bus
`define OFS_STATUS   8'h00
`define OFS_CTRL_A   8'h04
`define OFS_CTRL_B   8'h08
`define OFS_CTRL_C   8'h0c
`define OFS_RESULT0  8'h10
`define OFS_RESULT1  8'h14
`define OFS_RESULT2  8'h18
`define OFS_RESULT3  8'h1c
// Upper address nibble shared by the four result slots
`define RESULT_PAGE  4'h1
// converter_ctrl_a fields
`define A_ENABLE     0
`define A_INTERNAL_REF_SELECT     1
`define A_IRQEN      2
`define A_MASK       8'h07
// converter_ctrl_b fields
`define B_START      7
`define B_BURST      5
`define B_REPEAT     4
`define B_CHAN_HI    2
`define B_CHAN_LO    0
`define B_MASK       8'hb7
// converter_ctrl_c fields
`define C_DELAY_HI   5
`define C_DELAY_LO   3
`define C_DIV_HI     2
`define C_DIV_LO     0
`define C_MASK       8'h3f
// converter_status fields
`define S_DONE       0
`define S_BUSY       1
`define S_OVERRUN    2
`define S_IDX_LO     4
`define S_IDX_HI     5
// Reset values
`define RST_BYTE     8'h00
`define IDX_START    2'h3
// Conversion core length in converter clocks
`define CONV_CLOCKS  4'ha
// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD    3'h2
`endif

// File: tb/adc_sample_source.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sample_source (
	input  wire logic [2:0] inputSelect,
	output var  logic [7:0] sampleIn
);
	// Each channel gives a distinct code, so a result slot shows which input was routed
	assign sampleIn = {inputSelect, 5'h0a};
endmodule // adc_sample_source
`default_nettype wire

// File: tb/adc_sequencer_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_props (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        internalRefOn,
	input wire logic        converterPowered,
	input wire logic        irqRequest
);
	wire take = hsel & hready & (htrans == 2'h2);
	wire wrA  = take & hwrite & (haddr == 8'h04);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_ready_always: assert property (hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp)
		else $error("hresp not OKAY");
	chk_rdata_byte: assert property (hrdata[31:8] == 24'h0)
		else $error("hrdata upper bits set");
	chk_irq_powered: assert property (irqRequest |-> converterPowered)
		else $error("irq while disabled");
	chk_ref_powered: assert property (internalRefOn |-> converterPowered)
		else $error("reference on while disabled");
	chk_reset_clears: assert property ($fell(rst) |-> !converterPowered && !irqRequest)
		else $error("control not cleared by reset");
	chk_ctrl_a_write: assert property (wrA ##1 1'b1 |=> converterPowered == $past(hwdata[0])
		&& internalRefOn == ($past(hwdata[0]) & $past(hwdata[1])))
		else $error("enable or reference wrong after write");
	chk_irq_masked: assert property (wrA ##1 !hwdata[2] |=> !irqRequest)
		else $error("irq with enable clear");
	chk_read_clears: assert property (take && !hwrite && haddr[7:4] == 4'h1 |-> ##[1:2] !irqRequest)
		else $error("irq kept after result read");
endmodule // adc_sequencer_control_props
`default_nettype wire

// File: tb/adc_sequencer_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module adc_sequencer_control_test;
	logic        clk_sys = 0;
	logic        rst = 1;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic [7:0]  haddr = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] r;
	wire  [31:0] hrdata;
	wire  [7:0]  sampleIn;
	wire  [2:0]  inputSelect;
	wire         hreadyout, hresp, internalRefOn, converterPowered, irqRequest;
	int          fails = 0, compares = 0, n, t, cd, dd;
	always #5 clk_sys = ~clk_sys;
	adc_sequencer_control DUT (.clk_sys, .rst, .warmRst(1'b0), .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sampleIn, .inputSelect,
		.internalRefOn, .converterPowered, .irqRequest);
	adc_sample_source src (.inputSelect, .sampleIn);
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge clk_sys);
		while (!hreadyout) @(posedge clk_sys);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (!hreadyout) @(posedge clk_sys);
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] a); xfer(a, 1'b0, 32'h0); endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(a, 1'b1, d); endtask
	task automatic waitDone;
		r = 0;
		for (n = 0; n < 1000 && !r[0]; n++) rd(8'h00);
		`CHK(r[0], 1'b1)
	endtask
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		fails++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 0;
		for (int i = 0; i < 5; i++) begin
			rd(8'(i == 4 ? 32 : 4 * i));
			`CHK(r, (i == 0) ? 32'h30 : 32'h0)
		end
		wr(8'h0c, 32'hff);
		rd(8'h0c);
		`CHK(r, 32'h3f)
		wr(8'h0c, 32'h1);
		wr(8'h04, 32'h2);
		rd(8'h04);
		`CHK(internalRefOn, 1'b0)
		wr(8'h04, 32'hff);
		rd(8'h04);
		`CHK(r, 32'h7)
		`CHK(internalRefOn, 1'b1)
		for (int c = 0; c < 8; c++) begin
			wr(8'h08, 32'h80 | c);
			waitDone;
			`CHK(irqRequest, 1'b1)
			`CHK(r[5:0], 6'h01)
			rd(8'h08);
			`CHK(r, 32'h0 | c)
			rd(8'h10);
			`CHK(r[7:0], {3'(c), 5'h0a})
			rd(8'h00);
			`CHK(r[0], 1'b0)
		end
		wr(8'h08, 32'ha6);
		waitDone;
		`CHK(r[5:0], 6'h31)
		rd(8'h08);
		`CHK(r, 32'h26)
		for (int k = 0; k < 4; k++) begin
			rd(8'(16 + 4 * k));
			`CHK(r[7:0], {3'(6 + k), 5'h0a})
		end
		// Two results into the same unread slot
		wr(8'h08, 32'h82);
		waitDone;
		wr(8'h08, 32'h82);
		r = 0;
		for (n = 0; n < 1000 && !r[2]; n++) rd(8'h00);
		`CHK(r[2:0], 3'h5)
		wr(8'h00, 32'h4);
		rd(8'h00);
		`CHK(r[2:0], 3'h1)
		// Stale done from the overrun run would end the next wait at once
		rd(8'h10);
		wr(8'h08, 32'h93);
		waitDone;
		`CHK(r[5:4], 2'h3)
		rd(8'h08);
		`CHK(r[7], 1'b1)
		wr(8'h08, 32'h13);
		r = 32'h2;
		for (n = 0; n < 100 && r[1]; n++) rd(8'h00);
		for (int k = 0; k < 4; k++) begin
			rd(8'(16 + 4 * k));
			`CHK(r[7:0], 8'h6a)
		end
		rd(8'h00);
		`CHK(r[1:0], 2'h0)
		wr(8'h00, 32'h4);
		// Conversion time grows with divider codes 0 to 5 and delay codes 0 to 6
		for (int i = 0; i < 13; i++) begin
			cd = i < 6 ? i : 0;
			dd = i < 6 ? 0 : i - 6;
			wr(8'h04, 32'h4);
			wr(8'h0c, 32'((dd << 3) | cd));
			wr(8'h04, 32'h5);
			wr(8'h08, 32'h81);
			waitDone;
			t = ((1 << dd) + 11) << cd;
			`CHK(2 * n >= t - (2 << cd) - 4 && 2 * n <= t + (2 << cd) + 8, 1'b1)
			rd(8'h10);
		end
		wr(8'h08, 32'h80);
		wr(8'h04, 32'h6);
		rd(8'h00);
		`CHK(r[2:0], 3'h0)
		rd(8'h08);
		`CHK(r[7], 1'b0)
		wr(8'h04, 32'h7);
		repeat (50) rd(8'h00);
		`CHK(r[1:0], 2'h0)
		// Main reset while idle: control cleared, result slots kept
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		rd(8'h10);
		`CHK(r, 32'h2a)
		rd(8'h00);
		`CHK(r, 32'h30)
		end_of_test;
	end
endmodule // adc_sequencer_control_test
bind adc_sequencer_control adc_sequencer_control_props props (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hwdata, .hrdata, .hreadyout, .hresp, .internalRefOn, .converterPowered, .irqRequest);
`default_nettype wire
